/* pkg/nfc_pkg.sv */
/*
 * nfc_pkg: constants for the host-side parallel NOR flash controller:
 * command codes, unlock addresses, user operation codes, pin timings.
 * Assumes a 20 MHz sys_clk and a flash with asynchronous CE/WE/OE pins.
 */
package nfc_pkg;
  // clock
  localparam int CLK_NS = 50;

  // user operation codes
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_PROG = 3'h1;
  localparam logic [2:0] OP_CHIP = 3'h2;
  localparam logic [2:0] OP_SECT = 3'h3;
  localparam logic [2:0] OP_SUSP = 3'h4;
  localparam logic [2:0] OP_RESUME = 3'h5;
  localparam logic [2:0] OP_RESET = 3'h6;
  localparam logic [2:0] OP_IDENT = 3'h7;

  // command data values
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PROG = 8'ha0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_CHIP = 8'h10;
  localparam logic [7:0] CMD_SECT = 8'h30;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_SUSP = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;

  // unlock addresses, as user addresses of each width mode
  localparam logic [18:0] U1_WORD = 19'h00555;
  localparam logic [18:0] U2_WORD = 19'h002aa;
  localparam logic [18:0] U1_BYTE = 19'h00aaa;
  localparam logic [18:0] U2_BYTE = 19'h00555;

  // sector select field: word address bits 17:12
  localparam int SECT_LSB_WORD = 12;
  localparam int SECT_LSB_BYTE = 13;
  localparam logic [18:0] SECT_MASK_WORD = 19'h3f000;
  localparam logic [18:0] SECT_MASK_BYTE = 19'h7e000;

  // sequence lengths
  localparam logic [2:0] LEN_ONE = 3'h1;
  localparam logic [2:0] LEN_PROG = 3'h4;
  localparam logic [2:0] LEN_ERASE = 3'h6;
  localparam logic [2:0] LEN_IDENT = 3'h5;
  localparam logic [2:0] IDENT_READ_STEP = 3'h3;

  // pin timings in ns, then in cycles (least times round up)
  localparam int T_AS_NS = 50;
  localparam int T_WP_NS = 100;
  localparam int T_WPH_NS = 50;
  localparam int T_ACC_NS = 100;
  localparam int T_BUSY_NS = 500;
  localparam int T_PWRUP_NS = 50000;
  localparam int SYNC_LAT = 4;
  localparam int T_AS_CYC = (T_AS_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WPH_CYC = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RD_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT;
  localparam int T_BUSY_CYC = (T_BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_PWRUP_CYC = (T_PWRUP_NS + CLK_NS - 1) / CLK_NS;

  // controller states, one-hot
  typedef enum logic [5:0] {
    ST_PWRUP = 6'h01,
    ST_IDLE = 6'h02,
    ST_SETUP = 6'h04,
    ST_STROBE = 6'h08,
    ST_RECOVER = 6'h10,
    ST_READ = 6'h20
  } nfc_state_t;
endpackage

/* design/nfc_pin_sync.sv */
/*
 * nfc_pin_sync: three-flop synchroniser for a bus of pin inputs; each
 * output bit changes once the second and third stages agree.
 * Assumes inputs are asynchronous to sys_clk and stable for >= 3 cycles.
 */
`timescale 1ns/1ps
module nfc_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic lvl_r;
      // first stage feeds only the second; it may be metastable
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          s1_r <= RST_VAL[i];
          s2_r <= RST_VAL[i];
          s3_r <= RST_VAL[i];
        end else begin
          s1_r <= pin_in[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
        end
      end
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          lvl_r <= RST_VAL[i];
        end else if (s2_r == s3_r) begin
          lvl_r <= s3_r;
        end
      end
      assign level_out[i] = lvl_r;
    end
  endgenerate
endmodule

/* design/nfc_host.sv */
/*
 * nfc_host: host controller that drives a parallel NOR flash through its
 * CE/WE/OE, address, data, width-select and ready pins, issuing unlock
 * command sequences for user operations given at a valid/ready port.
 * Assumes the flash pins sit outside the sys_clk domain.
 */
// Behaviour
// R01: below supply_lockout_threshold writes refused; host holds pins idle, aborts.
// R02: above threshold host keeps controls at levels forming no stray write.
// R03: no write starts on control pulses shorter than about 5 ns.
// R04: writes inhibited while OE low, CE high, or WE high.
// R05: write only with CE and WE low and OE high; host drives that.
// R06: all three controls low counts as read, never a write.
// R07: after power-up device reads array and locks out writes for a while.
// R08: wrong address, data or order aborts sequence back to read array.
// R09: unlock addresses 555/2AA in word mode, AAA/555 in byte mode.
// R10: program is AA, 55, A0 to unlock addresses, then data at target.
// R11: erase is AA,55,80,AA,55 then 10 for chip or 30 at sector.
// R12: sector chosen by sector_select_bits only.
// R13: F0 reset, B0 suspend, 30 resume are single cycles at any address.
// R14: ident is AA,55,90; then maker or part code read at fixed offsets.
// R15: ident read at sector offset X02/X04 gives protection state 01 or 00.
// R16: array data readable after power-up and after program or erase ends.
// R17: in suspend, suspended sectors read status, others read array data.
// R18: after timeout or in ident mode, reset command needed for array reads.
// R19: address latched on later falling, data on earlier rising CE/WE edge.
// R20: width-select high uses sixteen data lines; low makes DQ15 address LSB.
// R21: busy program or erase ignores reset; sector erase accepts only suspend.
// R22: synchronous device decoder advances only on write completion edges.
`timescale 1ns/1ps
module nfc_host
  import nfc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [2:0] cmd_op,
  input wire logic [18:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  input wire logic word_mode,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic busy,
  output logic erase_suspended,
  input wire logic supply_ok,
  output logic [17:0] f_addr,
  input wire logic [15:0] f_dq_in,
  output logic [15:0] f_dq_out,
  output logic [15:0] f_dq_oe,
  output logic f_ce_n,
  output logic f_we_n,
  output logic f_oe_n,
  output logic f_byte_n,
  input wire logic operation_done_n
);
  nfc_state_t st_r;
  logic [11:0] cnt_r;
  logic [2:0] step_r;
  logic [2:0] op_r;
  logic [18:0] uaddr_r;
  logic [15:0] udata_r;
  logic mode_r;
  logic [17:0] addr_r;
  logic [15:0] dq_out_r;
  logic [15:0] dq_oe_r;
  logic ce_n_r;
  logic we_n_r;
  logic oe_n_r;
  logic rsp_valid_r;
  logic [15:0] rsp_data_r;
  logic dev_busy_r;
  logic [4:0] arm_r;
  logic sect_erase_r;
  logic susp_r;
  logic [17:0] sync_lvl;
  logic [15:0] dq_s;
  logic done_s;
  logic supply_s;
  logic op_ok;
  logic accept;
  logic fin;
  logic last_step;
  logic step_rd;
  logic [18:0] step_addr;
  logic [15:0] step_data;

  // pins from the flash and the supply monitor are asynchronous
  nfc_pin_sync #(.W(18), .RST_VAL(18'h10000)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in({supply_ok, operation_done_n, f_dq_in}),
    .level_out(sync_lvl)
  );
  assign supply_s = sync_lvl[17];
  assign done_s = sync_lvl[16];
  assign dq_s = sync_lvl[15:0];

  function automatic logic [2:0] seq_len(input logic [2:0] op);
    case (op)
      OP_PROG: seq_len = LEN_PROG;
      OP_CHIP, OP_SECT: seq_len = LEN_ERASE;
      OP_IDENT: seq_len = LEN_IDENT;
      default: seq_len = LEN_ONE;
    endcase
  endfunction

  // one step of a command sequence: read flag, user address, data
  always_comb begin
    logic [18:0] u1;
    logic [18:0] u2;
    logic [18:0] smask;
    u1 = mode_r ? U1_WORD : U1_BYTE; // [R09]
    u2 = mode_r ? U2_WORD : U2_BYTE; // [R09]
    smask = mode_r ? SECT_MASK_WORD : SECT_MASK_BYTE; // [R12]
    step_rd = 1'b0;
    step_addr = u1;
    step_data = {8'h00, CMD_UNLOCK1};
    if (op_r == OP_READ) begin
      step_rd = 1'b1; // [R16]
      step_addr = uaddr_r;
    end else if (op_r == OP_SUSP) begin
      step_data = {8'h00, CMD_SUSP}; // [R13]
    end else if (op_r == OP_RESUME) begin
      step_data = {8'h00, CMD_RESUME}; // [R13]
    end else if (op_r == OP_RESET) begin
      step_data = {8'h00, CMD_RESET}; // [R13]
    end else begin
      case (step_r)
        3'h0: step_data = {8'h00, CMD_UNLOCK1};
        3'h1: begin
          step_addr = u2;
          step_data = {8'h00, CMD_UNLOCK2};
        end
        3'h2: begin
          if (op_r == OP_PROG) begin
            step_data = {8'h00, CMD_PROG}; // [R10]
          end else if (op_r == OP_IDENT) begin
            step_data = {8'h00, CMD_IDENT}; // [R14]
          end else begin
            step_data = {8'h00, CMD_ERASE}; // [R11]
          end
        end
        3'h3: begin
          if (op_r == OP_PROG) begin
            step_addr = uaddr_r; // [R10]
            step_data = udata_r;
          end else if (op_r == OP_IDENT) begin
            step_rd = 1'b1; // [R14] [R15]
            step_addr = uaddr_r;
          end
        end
        3'h4: begin
          if (op_r == OP_IDENT) begin
            step_data = {8'h00, CMD_RESET}; // [R18]
          end else begin
            step_addr = u2;
            step_data = {8'h00, CMD_UNLOCK2};
          end
        end
        default: begin
          if (op_r == OP_SECT) begin
            step_addr = uaddr_r & smask; // [R11] [R12]
            step_data = {8'h00, CMD_SECT};
          end else begin
            step_data = {8'h00, CMD_CHIP}; // [R11]
          end
        end
      endcase
    end
  end

  // what the device can take now; reset while busy would be ignored
  always_comb begin
    case (cmd_op)
      OP_SUSP: op_ok = dev_busy_r && sect_erase_r && !susp_r;
      OP_RESUME: op_ok = !dev_busy_r && susp_r;
      OP_CHIP, OP_SECT, OP_IDENT: op_ok = !dev_busy_r && !susp_r;
      default: op_ok = !dev_busy_r; // [R21]
    endcase
  end
  assign cmd_ready = (st_r == ST_IDLE) && supply_s && op_ok; // [R07]
  assign accept = cmd_valid && cmd_ready;
  assign last_step = (step_r == seq_len(op_r) - 3'h1);
  assign fin = last_step && (((st_r == ST_RECOVER) &&
               (cnt_r == 12'(T_WPH_CYC - 1))) ||
               ((st_r == ST_READ) && (cnt_r == 12'(T_RD_CYC - 1))));

  // sequencing; a supply drop aborts and restarts the power-up wait
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= ST_PWRUP;
      cnt_r <= 12'h000;
      step_r <= 3'h0;
      op_r <= OP_READ;
      uaddr_r <= 19'h00000;
      udata_r <= 16'h0000;
      mode_r <= 1'b1;
    end else if (!supply_s) begin
      st_r <= ST_PWRUP; // [R01]
      cnt_r <= 12'h000;
    end else begin
      cnt_r <= cnt_r + 12'h001;
      case (st_r)
        ST_PWRUP: begin
          mode_r <= word_mode;
          if (cnt_r == 12'(T_PWRUP_CYC - 1)) begin
            st_r <= ST_IDLE; // [R07]
          end
        end
        ST_IDLE: begin
          cnt_r <= 12'h000;
          mode_r <= word_mode;
          if (accept) begin
            op_r <= cmd_op;
            uaddr_r <= cmd_addr;
            udata_r <= cmd_data;
            step_r <= 3'h0;
            st_r <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (step_rd) begin
            st_r <= ST_READ;
            cnt_r <= 12'h000;
          end else if (cnt_r >= 12'(T_AS_CYC - 1)) begin
            st_r <= ST_STROBE;
            cnt_r <= 12'h000;
          end
        end
        ST_STROBE: begin
          if (cnt_r == 12'(T_WP_CYC - 1)) begin
            st_r <= ST_RECOVER; // [R03]
            cnt_r <= 12'h000;
          end
        end
        ST_RECOVER, ST_READ: begin
          if (fin) begin
            st_r <= ST_IDLE;
          end else if ((st_r == ST_RECOVER) ?
                       (cnt_r == 12'(T_WPH_CYC - 1)) :
                       (cnt_r == 12'(T_RD_CYC - 1))) begin
            step_r <= step_r + 3'h1; // [R08]
            st_r <= ST_SETUP;
            cnt_r <= 12'h000;
          end
        end
        default: st_r <= ST_PWRUP;
      endcase
    end
  end

  // pin drive; WE low only in strobe, OE low only in read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ce_n_r <= 1'b1;
      we_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      addr_r <= 18'h00000;
      dq_out_r <= 16'h0000;
      dq_oe_r <= 16'h0000;
    end else begin
      ce_n_r <= 1'b1; // [R02]
      we_n_r <= 1'b1; // [R04]
      oe_n_r <= 1'b1;
      dq_oe_r <= 16'h0000;
      // held through the finishing cycle so data outlasts the we rise
      if (supply_s && (st_r == ST_SETUP || st_r == ST_STROBE ||
          st_r == ST_RECOVER || st_r == ST_READ)) begin
        ce_n_r <= 1'b0;
        // address and data held across the strobe so both latch points see
        // the same values [R19]
        addr_r <= mode_r ? step_addr[17:0] : step_addr[18:1]; // [R20]
        dq_out_r <= mode_r ? step_data :
                    {step_addr[0], 7'h00, step_data[7:0]}; // [R20]
        if (step_rd) begin
          oe_n_r <= 1'b0; // [R06]
          dq_oe_r <= mode_r ? 16'h0000 : 16'h8000;
        end else begin
          dq_oe_r <= mode_r ? 16'hffff : 16'h80ff;
          // we falls a cycle after the address settles
          we_n_r <= (st_r != ST_STROBE); // [R05]
        end
      end
    end
  end

  // read data capture after access time plus synchroniser latency
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 16'h0000;
    end else begin
      rsp_valid_r <= 1'b0;
      if (st_r == ST_READ && cnt_r == 12'(T_RD_CYC - 1) && supply_s) begin
        rsp_valid_r <= 1'b1; // [R14] [R17]
        rsp_data_r <= mode_r ? dq_s : {8'h00, dq_s[7:0]};
      end
    end
  end

  // embedded operation tracking from the ready pin
  always_ff @(posedge sys_clk) begin
    if (rst || !supply_s) begin
      dev_busy_r <= 1'b0;
      arm_r <= 5'h00;
      sect_erase_r <= 1'b0;
      susp_r <= 1'b0;
    end else if (fin && op_r != OP_READ && op_r != OP_RESET &&
                 op_r != OP_IDENT) begin
      // ready may take a while to fall, so ignore it for a short window
      dev_busy_r <= 1'b1; // [R21]
      arm_r <= 5'(T_BUSY_CYC);
      if (op_r == OP_SECT) begin
        sect_erase_r <= 1'b1;
      end
      if (op_r == OP_SUSP) begin
        susp_r <= 1'b1; // [R17]
      end
      if (op_r == OP_RESUME) begin
        susp_r <= 1'b0;
      end
    end else if (arm_r != 5'h00) begin
      arm_r <= arm_r - 5'h01;
    end else if (dev_busy_r && done_s) begin
      dev_busy_r <= 1'b0; // [R16]
      if (!susp_r) begin
        sect_erase_r <= 1'b0;
      end
    end
  end

  assign f_addr = addr_r;
  assign f_dq_out = dq_out_r;
  assign f_dq_oe = dq_oe_r;
  assign f_ce_n = ce_n_r;
  assign f_we_n = we_n_r;
  assign f_oe_n = oe_n_r;
  assign f_byte_n = mode_r; // [R20]
  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;
  assign busy = dev_busy_r || (st_r != ST_IDLE);
  assign erase_suspended = susp_r;

  property p_no_all_low;
    @(posedge sys_clk) disable iff (rst)
      !(!f_ce_n && !f_we_n && !f_oe_n);
  endproperty
  a_no_all_low: assert property (p_no_all_low) // [R06]
    else $error("ce, we and oe all low");

  property p_write_combo;
    @(posedge sys_clk) disable iff (rst)
      !f_we_n |-> (!f_ce_n && f_oe_n && f_dq_oe[0]);
  endproperty
  a_write_combo: assert property (p_write_combo) // [R05]
    else $error("we low without ce low, oe high and data driven");

  property p_we_pulse;
    @(posedge sys_clk) disable iff (rst)
      $fell(f_we_n) |-> !f_we_n ##1 !f_we_n ##1 f_we_n;
  endproperty
  a_we_pulse: assert property (p_we_pulse) // [R03]
    else $error("write pulse not exactly two cycles");

  property p_idle_pins;
    @(posedge sys_clk) disable iff (rst)
      (st_r == ST_IDLE && $past(st_r) == ST_IDLE) |->
        (f_ce_n && f_we_n && f_oe_n && f_dq_oe == 16'h0000);
  endproperty
  a_idle_pins: assert property (p_idle_pins) // [R02]
    else $error("controls active while idle");

  property p_supply_off;
    @(posedge sys_clk) disable iff (rst)
      !supply_s |=> (f_we_n && st_r == ST_PWRUP && !cmd_ready);
  endproperty
  a_supply_off: assert property (p_supply_off) // [R01]
    else $error("activity while supply low");

  property p_pwrup_lock;
    @(posedge sys_clk) disable iff (rst)
      (st_r == ST_PWRUP) |-> (!cmd_ready && f_we_n);
  endproperty
  a_pwrup_lock: assert property (p_pwrup_lock) // [R07]
    else $error("command taken during power-up wait");

  property p_latch_stable;
    @(posedge sys_clk) disable iff (rst)
      (!f_we_n && $past(!f_we_n)) |->
        ($stable(f_addr) && $stable(f_dq_out));
  endproperty
  a_latch_stable: assert property (p_latch_stable) // [R19]
    else $error("address or data moved during strobe");

  property p_byte_lines;
    @(posedge sys_clk) disable iff (rst)
      !f_byte_n |-> (f_dq_oe[14:8] == 7'h00);
  endproperty
  a_byte_lines: assert property (p_byte_lines) // [R20]
    else $error("upper data lines driven in byte mode");

  property p_busy_refuse;
    @(posedge sys_clk) disable iff (rst)
      (dev_busy_r && cmd_op != OP_SUSP) |-> !cmd_ready;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) // [R21]
    else $error("command other than suspend offered while busy");

  property p_first_unlock;
    @(posedge sys_clk) disable iff (rst)
      ($fell(f_we_n) && step_r == 3'h0 && op_r != OP_SUSP &&
       op_r != OP_RESUME && op_r != OP_RESET) |->
        (f_dq_out[7:0] == 8'haa && f_addr[10:0] == 11'h555);
  endproperty
  a_first_unlock: assert property (p_first_unlock) // [R09]
    else $error("first unlock cycle wrong");
endmodule

/* sim/nfc_flash_model.sv */
/*
 * nfc_flash_model: behavioural parallel NOR flash facing nfc_host.
 * Assumes the bench resolves the data bus from the host's per-line enables.
 */
`timescale 1ns/1ps
module nfc_flash_model #(
  parameter int LOCK_NS = 20000,
  parameter int PROG_NS = 2000,
  parameter int ERASE_NS = 20000,
  parameter logic [15:0] MAKER = 16'h00a5, // arbitrary value
  parameter logic [15:0] PART = 16'h5a3c, // arbitrary value
  parameter logic [5:0] PROT_SECT = 6'h05,
  parameter logic [15:0] SUSP_STAT = 16'h004c
) (
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic byte_n,
  input wire logic [17:0] addr,
  input wire logic [15:0] dq_in,
  input wire logic supply_ok,
  output logic [15:0] dq_out,
  output logic done_n
);
  logic [7:0] mem [int];
  logic [18:0] ba, rba;
  logic [15:0] last = 16'h0;
  int step, prog_rem, erase_rem, esect, n_bad = 0, n_conflict = 0;
  bit ident, susp;
  time t_fall = 0, t_up = 0;

  // byte address; in byte mode the top data pin is the lowest address bit
  function automatic logic [18:0] norm(input logic [17:0] a, logic d15);
    return byte_n ? {a, 1'b0} : {a, d15};
  endfunction
  function automatic logic [7:0] rd8(input logic [18:0] b);
    return mem.exists(int'(b)) ? mem[int'(b)] : 8'hff;
  endfunction
  task automatic clear_all();
    step = 0;
    ident = 0;
    susp = 0;
    prog_rem = 0;
    erase_rem = 0;
    esect = -2;
  endtask
  task automatic abort_seq();
    step = 0;
    ident = 0;
    n_bad++;
  endtask
  task automatic start_erase(input int s);
    esect = s;
    erase_rem = ERASE_NS;
  endtask

  task automatic write_cycle(input logic [15:0] d);
    logic u1, u2;
    logic [7:0] c;
    u1 = ba[11:1] == 11'h555;
    u2 = ba[11:1] == 11'h2aa;
    c = d[7:0];
    if (prog_rem > 0 || (erase_rem > 0 && !susp)) begin
      if (c == 8'hb0 && prog_rem == 0 && esect >= 0) susp = 1;
    end else begin
      case (step)
        0: if (c == 8'haa && u1) step = 1;
          else if (c == 8'hf0) ident = 0;
          else if (c == 8'h30 && susp) susp = 0;
          else abort_seq();
        1: if (c == 8'h55 && u2) step = 2;
          else abort_seq();
        2: if (u1 && c == 8'ha0) step = 3;
          else if (u1 && c == 8'h80) step = 4;
          else if (u1 && c == 8'h90) step = 7;
          else abort_seq();
        3: begin
          mem[int'(ba)] = rd8(ba) & d[7:0];
          if (byte_n) mem[int'(ba) + 1] = rd8(ba + 19'h1) & d[15:8];
          prog_rem = PROG_NS;
          step = 0;
        end
        4: if (c == 8'haa && u1) step = 5;
          else abort_seq();
        5: if (c == 8'h55 && u2) step = 6;
          else abort_seq();
        default: begin
          step = 0;
          if (c == 8'h10 && u1) start_erase(-1);
          else if (c == 8'h30) start_erase(int'(ba[18:13]));
          else abort_seq();
        end
      endcase
      if (step == 7) begin
        ident = 1;
        step = 0;
      end
    end
  endtask

  initial begin
    clear_all();
    done_n = 1'b1;
    dq_out = 16'hffff;
  end
  // address on the later falling edge of ce_n and we_n
  always @(negedge we_n or negedge ce_n) begin
    t_fall = $time;
    if (!we_n && !ce_n) ba = norm(addr, dq_in[15]);
  end
  always @(negedge oe_n or negedge we_n) begin
    if (!ce_n && !oe_n && !we_n) n_conflict++;
  end
  // data on the earlier rising edge; here ce_n rises last, or together with we_n when the supply drops
  always @(posedge we_n) begin
    if (!ce_n && oe_n && supply_ok
        && $time - t_fall >= 5
        && $time >= t_up + LOCK_NS)
      write_cycle(dq_in);
  end
  always @(negedge supply_ok) clear_all();
  always @(posedge supply_ok) t_up = $time;
  // coarse time base; suspend freezes the erase count
  always begin
    #10;
    if (prog_rem > 0) prog_rem -= 10;
    else if (erase_rem > 0 && !susp) begin
      erase_rem -= 10;
      if (erase_rem <= 0) foreach (mem[k])
        if (esect < 0 || k[18:13] == esect[5:0]) mem[k] = 8'hff;
    end
    done_n = !(prog_rem > 0 || (erase_rem > 0 && !susp));
  end
  // a released bus shows the inverse of its last value, never a hold
  always begin
    #5;
    rba = norm(addr, dq_in[15]);
    if (!ce_n && !oe_n && supply_ok) begin
      if (ident) case (rba[2:1])
        2'h0: last = MAKER;
        2'h1: last = PART;
        default: last = {15'h0, rba[18:13] == PROT_SECT};
      endcase
      else if (susp && int'(rba[18:13]) == esect) last = SUSP_STAT;
      else if (byte_n) last = {rd8(rba | 19'h1), rd8(rba)};
      else last = {8'h00, rd8(rba)};
      dq_out = byte_n ? last : {~last[15:8], last[7:0]};
    end else dq_out = ~last;
  end
endmodule

/* sim/nfc_host_tb.sv */
/*
 * nfc_host_tb: self-checking bench for nfc_host against a flash model.
 * Assumes nfc_pkg and nfc_flash_model are compiled before it.
 */
`timescale 1ns/1ps
module nfc_host_tb;
  import nfc_pkg::*;
  localparam logic [15:0] MAKER_ID = 16'h00a5; // arbitrary value
  localparam logic [15:0] PART_ID = 16'h5a3c; // arbitrary value
  logic sys_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, word_mode = 1'b1;
  logic supply_ok = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [18:0] cmd_addr = 19'h0, a1, a2;
  logic [15:0] cmd_data = 16'h0, d1, got;
  logic cmd_ready, rsp_valid, busy, erase_suspended;
  logic f_ce_n, f_we_n, f_oe_n, f_byte_n, done_n;
  logic [15:0] rsp_data, f_dq_out, f_dq_oe, m_dq, bus;
  logic [17:0] f_addr;
  logic [18:0] id_a [4];
  logic [15:0] id_e [4];
  logic [7:0] ref_mem [int];
  int n_errors = 0, checks_done = 0, seed = 30787;

  assign bus = (f_dq_oe & f_dq_out) | (~f_dq_oe & m_dq);
  always #25 sys_clk = ~sys_clk;

  nfc_host i_dut (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .word_mode(word_mode), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .busy(busy), .erase_suspended(erase_suspended),
    .supply_ok(supply_ok), .f_addr(f_addr), .f_dq_in(bus),
    .f_dq_out(f_dq_out), .f_dq_oe(f_dq_oe), .f_ce_n(f_ce_n),
    .f_we_n(f_we_n), .f_oe_n(f_oe_n), .f_byte_n(f_byte_n),
    .operation_done_n(done_n));
  nfc_flash_model #(.MAKER(MAKER_ID), .PART(PART_ID)) i_flash (
    .ce_n(f_ce_n), .we_n(f_we_n), .oe_n(f_oe_n), .byte_n(f_byte_n),
    .addr(f_addr), .dq_in(bus), .supply_ok(supply_ok), .dq_out(m_dq),
    .done_n(done_n));

  task automatic check(input logic [15:0] got_v, exp_v);
    checks_done++;
    if (got_v !== exp_v) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [7:0] rb(input int k);
    return ref_mem.exists(k) ? ref_mem[k] : 8'hff;
  endfunction
  function automatic logic [15:0] wexp(input logic [18:0] a);
    return {rb(2 * int'(a) + 1), rb(2 * int'(a))};
  endfunction
  // entered just after either clock edge; returns just after a rising one
  task automatic idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      n++;
      @(negedge sys_clk);
    end
    if (n >= 3000) check(16'h1, 16'h0);
    @(posedge sys_clk);
  endtask
  task automatic issue(input logic [2:0] op, input logic [18:0] a,
    input logic [15:0] d, input bit wait_done);
    int n;
    n = 0;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    @(negedge sys_clk);
    while (cmd_ready !== 1'b1 && n < 3000) begin
      n++;
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    got = 16'hxxxx;
    while (wait_done && n < 6000) begin
      n++;
      @(negedge sys_clk);
      if (rsp_valid === 1'b1) got = rsp_data;
      if (busy === 1'b0) break;
    end
    if (n >= 3000) check(16'h1, 16'h0);
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [18:0] a, input logic [15:0] exp_v);
    issue(OP_READ, a, 16'h0, 1'b1);
    check(got, exp_v);
  endtask
  // reset must stay refused while the device is busy programming
  task automatic pw(input logic [18:0] a, input logic [15:0] d);
    ref_mem[2 * int'(a)] = rb(2 * int'(a)) & d[7:0];
    ref_mem[2 * int'(a) + 1] = rb(2 * int'(a) + 1) & d[15:8];
    issue(OP_PROG, a, d, 1'b0);
    cmd_op <= OP_RESET;
    repeat (25) @(negedge sys_clk);
    check({15'h0, cmd_ready}, 16'h0);
    idle();
  endtask

  initial begin
    #(50 * 60000);
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    id_a = '{19'h00100, 19'h3f001, 19'h05002, 19'h06002};
    id_e = '{MAKER_ID, PART_ID, 16'h0001, 16'h0000};
    repeat (20) @(posedge sys_clk);
    check({13'h0, f_ce_n, f_we_n, f_oe_n}, 16'h7);
    rst <= 1'b0;
    supply_ok <= 1'b1;
    repeat (100) @(negedge sys_clk);
    check({15'h0, cmd_ready}, 16'h0);
    @(posedge sys_clk);
    a1 = 19'($random(seed)) & 19'h3ffff;
    rd(a1, 16'hffff);
    for (int i = 0; i < 3; i++) begin
      a2 = 19'($random(seed)) & 19'h3ffff;
      d1 = 16'($random(seed));
      pw(a2, d1);
      rd(a2, wexp(a2));
    end
    for (int i = 0; i < 4; i++) begin
      issue(OP_IDENT, id_a[i], 16'h0, 1'b1);
      check(got, id_e[i]);
    end
    rd(a2, wexp(a2));
    a1 = a2 ^ 19'h20000;
    issue(OP_SECT, a2, 16'h0, 1'b0);
    issue(OP_SUSP, 19'($random(seed)), 16'h0, 1'b1);
    check({15'h0, erase_suspended}, 16'h1);
    rd(a2, 16'h004c);
    pw(a1, 16'($random(seed)));
    rd(a1, wexp(a1));
    issue(OP_RESUME, 19'($random(seed)), 16'h0, 1'b1);
    foreach (ref_mem[k]) if (k[18:13] == a2[17:12]) ref_mem[k] = 8'hff;
    rd(a2, 16'hffff);
    rd(a1, wexp(a1));
    issue(OP_RESET, 19'($random(seed)), 16'h0, 1'b1);
    issue(OP_CHIP, 19'h0, 16'h0, 1'b1);
    ref_mem.delete();
    rd(a1, 16'hffff);
    word_mode <= 1'b0;
    @(posedge sys_clk);
    a1 = 19'($random(seed));
    d1 = 16'($random(seed)) & 16'h00ff;
    issue(OP_PROG, a1, d1, 1'b1);
    idle();
    check({15'h0, f_byte_n}, 16'h0);
    rd(a1, d1);
    rd(a1 ^ 19'h1, 16'h00ff);
    issue(OP_IDENT, 19'h00200, 16'h0, 1'b1);
    check(got, {8'h00, MAKER_ID[7:0]});
    a2 = a1 ^ 19'h2;
    issue(OP_PROG, a2, 16'h0000, 1'b0);
    repeat (3) @(posedge sys_clk);
    supply_ok <= 1'b0;
    repeat (10) @(negedge sys_clk);
    check({14'h0, cmd_ready, f_we_n}, 16'h1);
    @(posedge sys_clk);
    supply_ok <= 1'b1;
    rd(a2, 16'h00ff);
    check(16'(i_flash.n_bad), 16'h0);
    check(16'(i_flash.n_conflict), 16'h0);
    finish_test();
  end
endmodule
